/* src/iort_access_timer.sv */
// Purpose: Times each core access to I/O registers across clock ratios
// Assumes: Divider inputs come from core-clock logic, value 0 acts as 1
// Notes:   One access in flight; response only after target completes

`timescale 1ns/1ps
`default_nettype none

module iort_access_timer
  import iort_pkg::*;
#(
  parameter int unsigned ADDR_W = 32,
  parameter int unsigned DATA_W = 32,
  parameter int unsigned DIV_W  = 4,
  parameter int unsigned CYC_W  = 4,
  parameter int unsigned LAT_W  = 8
) (
  // Clock and reset
  input  wire  logic              clock,
  input  wire  logic              srst,
  // Clock ratios
  input  wire  logic [DIV_W-1:0]  pclk_div,
  input  wire  logic [DIV_W-1:0]  flash_interface_clock_div,
  input  wire  logic [DIV_W-1:0]  bclk_div,
  // Core request
  input  wire  logic              req_valid,
  input  wire  logic              req_write,
  input  wire  logic [2:0]        req_bus,
  input  wire  logic              req_flash,
  input  wire  logic              req_bus_err,
  input  wire  logic [CYC_W-1:0]  req_periph_cycles,
  input  wire  logic [ADDR_W-1:0] req_addr,
  input  wire  logic [DATA_W-1:0] req_wdata,
  input  wire  logic              main_bus_busy,
  output logic                    req_ready,
  // Core response
  output logic                    rsp_valid,
  output logic [DATA_W-1:0]       rsp_rdata,
  output logic [LAT_W-1:0]        rsp_cycles,
  // Target register side
  input  wire  logic [DATA_W-1:0] tgt_rdata,
  output logic                    tgt_strobe,
  output logic [2:0]              tgt_bus,
  output logic                    tgt_write,
  output logic [ADDR_W-1:0]       tgt_addr,
  output logic [DATA_W-1:0]       tgt_wdata
);

  // ***************************************************
  // Elaboration checks
  // ***************************************************
  if (DIV_W < 1 || CYC_W < 1 || LAT_W < 2 || ADDR_W < 1 || DATA_W < 1) begin
    $error("iort_access_timer: unsupported width parameter");
  end

  // ***************************************************
  // Derived clock phase counters
  // ***************************************************
  logic [DIV_W-1:0] div_sel [IORT_CLK_N];
  logic [DIV_W-1:0] phase_reg  [IORT_CLK_N];
  logic [DIV_W-1:0] phase_next [IORT_CLK_N];
  logic [IORT_CLK_N-1:0] clk_edge;

  assign div_sel[IORT_CLK_PERIPH] = pclk_div;
  assign div_sel[IORT_CLK_FLASH]  = flash_interface_clock_div;
  assign div_sel[IORT_CLK_EXTBUS] = bclk_div;

  // Edge marks the last core cycle of each slow period
  for (genvar g = 0; g < IORT_CLK_N; g++) begin : g_phase
    always_comb begin
      clk_edge[g] = (div_sel[g] <= DIV_W'(1))
                    || (phase_reg[g] >= div_sel[g] - DIV_W'(1));
      phase_next[g] = clk_edge[g] ? '0 : phase_reg[g] + DIV_W'(1);
    end
    always_ff @(posedge clock) begin
      if (srst) begin
        phase_reg[g] <= '0;
      end else begin
        phase_reg[g] <= phase_next[g];
      end
    end
  end

  // ***************************************************
  // Access sequencing
  // ***************************************************
  iort_state_t       state_reg,  state_next;
  logic              ready_reg,  ready_next;
  logic              rsp_reg,    rsp_next;
  logic [DATA_W-1:0] rdata_reg,  rdata_next;
  logic [LAT_W-1:0]  lat_reg,    lat_next;
  logic [LAT_W-1:0]  cyc_reg,    cyc_next;
  logic              stb_reg,    stb_next;
  logic [2:0]        bus_reg,    bus_next;
  logic              wr_reg,     wr_next;
  logic [ADDR_W-1:0] addr_reg,   addr_next;
  logic [DATA_W-1:0] wdata_reg,  wdata_next;
  logic              sync_reg,   sync_next;
  logic [1:0]        csel_reg,   csel_next;
  logic [CYC_W-1:0]  pcnt_reg,   pcnt_next;
  logic              need_sync;
  logic [1:0]        csel_req;
  logic              sel_edge;

  // Which requests cross a divided clock, and which clock
  always_comb begin
    need_sync = ((req_bus >= IORT_BUS_P2) && (req_bus <= IORT_BUS_P6))
                || ((req_bus == IORT_BUS_EXT) && !req_bus_err);
    if (req_bus == IORT_BUS_EXT) begin
      csel_req = 2'(IORT_CLK_EXTBUS);
    end else if (req_flash) begin
      csel_req = 2'(IORT_CLK_FLASH);
    end else begin
      csel_req = 2'(IORT_CLK_PERIPH);
    end
    sel_edge = clk_edge[csel_reg];
  end

  // Next-state logic for the access engine
  always_comb begin
    state_next = state_reg;
    ready_next = ready_reg;
    rsp_next   = 1'b0;
    rdata_next = rdata_reg;
    lat_next   = lat_reg;
    cyc_next   = cyc_reg;
    stb_next   = stb_reg;
    bus_next   = bus_reg;
    wr_next    = wr_reg;
    addr_next  = addr_reg;
    wdata_next = wdata_reg;
    sync_next  = sync_reg;
    csel_next  = csel_reg;
    pcnt_next  = pcnt_reg;
    case (state_reg)
      IORT_ST_IDLE: begin
        // Held off while another master owns the main bus
        if (req_valid && ready_reg && !main_bus_busy) begin
          state_next = IORT_ST_MAIN;
          ready_next = 1'b0;
          bus_next   = req_bus;
          wr_next    = req_write;
          addr_next  = req_addr;
          wdata_next = req_wdata;
          sync_next  = need_sync;
          csel_next  = csel_req;
          pcnt_next  = (req_periph_cycles == '0) ? CYC_W'(1)
                                                 : req_periph_cycles;
          lat_next   = LAT_W'(IORT_MAIN_BUS_CYCLES);
        end
      end
      IORT_ST_MAIN: begin
        // Sync wait closes on the next slow edge, so main plus sync
        // never exceeds one slow period
        if (sync_reg && !sel_edge) begin
          state_next = IORT_ST_SYNC;
        end else begin
          state_next = IORT_ST_PERIPH;
          stb_next   = 1'b1;
        end
      end
      IORT_ST_SYNC: begin
        lat_next = lat_reg + LAT_W'(1);
        if (sel_edge) begin
          state_next = IORT_ST_PERIPH;
          stb_next   = 1'b1;
        end
      end
      IORT_ST_PERIPH: begin
        lat_next = lat_reg + LAT_W'(1);
        if (pcnt_reg <= CYC_W'(1)) begin
          // Answer only once the target finished, writes included
          state_next = IORT_ST_IDLE;
          stb_next   = 1'b0;
          rsp_next   = 1'b1;
          cyc_next   = lat_reg + LAT_W'(1);
          rdata_next = wr_reg ? '0 : tgt_rdata;
          ready_next = 1'b1;
        end else begin
          pcnt_next = pcnt_reg - CYC_W'(1);
        end
      end
      default: begin
        state_next = IORT_ST_IDLE;
        ready_next = 1'b1;
        stb_next   = 1'b0;
      end
    endcase
  end

  // Registers only; reset leaves the engine idle and ready
  always_ff @(posedge clock) begin
    if (srst) begin
      state_reg <= IORT_ST_IDLE;
      ready_reg <= 1'b1;
      rsp_reg   <= 1'b0;
      rdata_reg <= '0;
      lat_reg   <= '0;
      cyc_reg   <= '0;
      stb_reg   <= 1'b0;
      bus_reg   <= IORT_BUS_NONE;
      wr_reg    <= 1'b0;
      addr_reg  <= '0;
      wdata_reg <= '0;
      sync_reg  <= 1'b0;
      csel_reg  <= 2'(IORT_CLK_PERIPH);
      pcnt_reg  <= '0;
    end else begin
      state_reg <= state_next;
      ready_reg <= ready_next;
      rsp_reg   <= rsp_next;
      rdata_reg <= rdata_next;
      lat_reg   <= lat_next;
      cyc_reg   <= cyc_next;
      stb_reg   <= stb_next;
      bus_reg   <= bus_next;
      wr_reg    <= wr_next;
      addr_reg  <= addr_next;
      wdata_reg <= wdata_next;
      sync_reg  <= sync_next;
      csel_reg  <= csel_next;
      pcnt_reg  <= pcnt_next;
    end
  end

  // Outputs straight from flip-flops
  assign req_ready  = ready_reg;
  assign rsp_valid  = rsp_reg;
  assign rsp_rdata  = rdata_reg;
  assign rsp_cycles = cyc_reg;
  assign tgt_strobe = stb_reg;
  assign tgt_bus    = bus_reg;
  assign tgt_write  = wr_reg;
  assign tgt_addr   = addr_reg;
  assign tgt_wdata  = wdata_reg;

endmodule

`default_nettype wire

/* pkg/iort_pkg.sv */
// Purpose: Shared constants and types for the I/O register access timer
// Assumes: All clocks are integer divisions of the core clock
// Notes:   Bus codes match the target field of a request

package iort_pkg;

  // ***************************************************
  // Timing and encodings
  // ***************************************************
  localparam int unsigned IORT_MAIN_BUS_CYCLES = 1;  // Main internal bus
  localparam int unsigned IORT_CLK_N           = 3;  // Derived clocks
  localparam int unsigned IORT_CLK_PERIPH      = 0;
  localparam int unsigned IORT_CLK_FLASH       = 1;
  localparam int unsigned IORT_CLK_EXTBUS      = 2;

  localparam logic [2:0] IORT_BUS_NONE  = 3'h0;  // No peripheral bus
  localparam logic [2:0] IORT_BUS_P1    = 3'h1;  // Peripheral bus 1
  localparam logic [2:0] IORT_BUS_P2    = 3'h2;  // First synchronised bus
  localparam logic [2:0] IORT_BUS_P6    = 3'h6;  // Last peripheral bus
  localparam logic [2:0] IORT_BUS_EXT   = 3'h7;  // External bus control

  // Control states, one-hot
  typedef enum logic [3:0] {
    IORT_ST_IDLE   = 4'h1,
    IORT_ST_MAIN   = 4'h2,
    IORT_ST_SYNC   = 4'h4,
    IORT_ST_PERIPH = 4'h8
  } iort_state_t;

endpackage

/* test/iort_access_timer_properties.sv */
// Purpose: Port-level timing checks for the access timer
// Assumes: One core clock domain, synchronous reset
// Notes:   Helper state ages each access from the edge that takes it
`timescale 1ns/1ps
`default_nettype none
module iort_chk
  import iort_pkg::*;
#(parameter int unsigned DATA_W = 32, DIV_W = 4, CYC_W = 4, LAT_W = 8)
(
  // Control
  input wire logic clock, srst, req_valid, req_flash, req_bus_err,
  input wire logic main_bus_busy, req_ready, rsp_valid,
  input wire logic tgt_strobe, tgt_write,
  // Values
  input wire logic [DIV_W-1:0]  pclk_div, flash_interface_clock_div, bclk_div,
  input wire logic [2:0]        req_bus,
  input wire logic [CYC_W-1:0]  req_periph_cycles,
  input wire logic [LAT_W-1:0]  rsp_cycles,
  input wire logic [DATA_W-1:0] rsp_rdata, tgt_rdata
);
  // *****
  // Helper state
  // *****
  logic             sync_reg, sync_next;
  logic [7:0]       age_reg, age_next, stb_reg, stb_next;
  logic [7:0]       lim_reg, lim_next, per_reg, per_next;
  logic [DIV_W-1:0] sel;
  // Capture ratio and sync need at take; the request lines move after
  always_comb begin
    sel = (req_bus == IORT_BUS_EXT) ? bclk_div :
          req_flash ? flash_interface_clock_div : pclk_div;
    age_next  = age_reg + 8'h01;
    stb_next  = stb_reg + 8'(tgt_strobe);
    lim_next  = lim_reg;
    per_next  = per_reg;
    sync_next = sync_reg;
    if (req_valid && req_ready && !main_bus_busy) begin
      age_next  = 8'h01;
      stb_next  = 8'h00;
      lim_next  = (sel < 2) ? 8'h02 : 8'(sel) + 8'h01;
      per_next  = (req_periph_cycles == 0) ? 8'h01 : 8'(req_periph_cycles);
      sync_next = (req_bus >= IORT_BUS_P2 && req_bus <= IORT_BUS_P6) ||
                  (req_bus == IORT_BUS_EXT && !req_bus_err);
    end
  end
  // Registers only
  always_ff @(posedge clock) begin
    if (srst) begin
      {age_reg, stb_reg, lim_reg, per_reg, sync_reg} <= '0;
    end else begin
      {age_reg, stb_reg, lim_reg, per_reg, sync_reg} <=
        {age_next, stb_next, lim_next, per_next, sync_next};
    end
  end
  // *****
  // Assertions
  // *****
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  sequence s_take; req_valid && req_ready && !main_bus_busy; endsequence
  sequence s_done; req_ready ##1 !rsp_valid; endsequence
  // Age also counts the response cycle, so one above the latency
  total_time_a: assert property (rsp_valid |->
    rsp_cycles == age_reg - 8'h01)
    else $error("latency differs from elapsed cycles");
  periph_len_a: assert property (rsp_valid |-> stb_reg == per_reg)
    else $error("strobe length wrong");
  sync_gate_a: assert property ($rose(tgt_strobe) && !sync_reg |-> age_reg == 2)
    else $error("sync wait on unsynchronised target");
  slow_period_a: assert property ($rose(tgt_strobe) |-> age_reg <= lim_reg)
    else $error("main plus sync exceeds slow period");
  ready_back_a: assert property (rsp_valid |-> s_done)
    else $error("not ready after response");
  refuse_next_a: assert property (s_take |=> !req_ready && !rsp_valid)
    else $error("second access accepted in flight");
  busy_hold_a: assert property (req_valid && req_ready && main_bus_busy |=> req_ready && !tgt_strobe)
    else $error("access taken while bus busy");
  read_data_a: assert property (rsp_valid && !tgt_write |-> rsp_rdata == $past(tgt_rdata))
    else $error("read data not from target");
endmodule
bind iort_access_timer iort_chk #(.DATA_W(DATA_W), .DIV_W(DIV_W),
  .CYC_W(CYC_W), .LAT_W(LAT_W)) chk_u (.*);
`default_nettype wire

/* test/iort_tgt_model.sv */
// Purpose: Register bank on the far side of the timer
// Assumes: Four words, indexed by address bits 3:2
// Notes:   Idle data is inverted so a stale value never looks valid
`timescale 1ns/1ps
`default_nettype none
module iort_tgt_model (
  // Target side
  input  wire logic        clock, tgt_strobe, tgt_write,
  input  wire logic [31:0] tgt_addr, tgt_wdata,
  output logic      [31:0] tgt_rdata
);
  logic [31:0] mem_reg [4];
  logic [31:0] last_reg;
  // No sleep state here, so every write is legal
  always_ff @(posedge clock) begin
    if (tgt_strobe && tgt_write) mem_reg[tgt_addr[3:2]] <= tgt_wdata;
    if (tgt_strobe) last_reg <= tgt_rdata;
  end
  // Deselected bank shows the inverse of its last value
  assign tgt_rdata = tgt_strobe ? mem_reg[tgt_addr[3:2]] : ~last_reg;
endmodule
`default_nettype wire

/* test/tb_io_register_access_timing.sv */
// Purpose: Self-checking bench for the access timer
// Assumes: Core clock 250 MHz, register bank model on the far side
// Notes:   Sync wait depends on divider phase, so it is checked as a range
`timescale 1ns/1ps
`default_nettype none
module tb_io_register_access_timing;
  import iort_pkg::*;
  logic clock = 0, srst = 1, req_valid = 0, req_write = 0, req_flash = 0;
  logic req_bus_err = 0, main_bus_busy = 0, req_ready, rsp_valid;
  logic tgt_strobe, tgt_write;
  logic [3:0]  pclk_div = 4'h1, flash_interface_clock_div = 4'h1, bclk_div = 4'h1;
  logic [3:0]  req_periph_cycles = 4'h0;
  logic [2:0]  req_bus = 3'h0, tgt_bus;
  logic [31:0] req_addr = 32'h0, req_wdata = 32'h0, rsp_rdata, tgt_rdata;
  logic [31:0] tgt_addr, tgt_wdata;
  logic [7:0]  rsp_cycles;
  int num_errors = 0, compares = 0, cyc = 0;
  iort_access_timer dut_u (.*);
  iort_tgt_model tgt_u (.*);
  // Clock and hang guard
  initial forever #2 clock = ~clock;
  always @(posedge clock) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One access: hold until taken, then wait for the response pulse
  task automatic acc(input logic [2:0] b, input logic w, f, e,
                     input logic [31:0] a, d);
    int n = 0;
    {req_bus, req_write, req_flash, req_bus_err} = {b, w, f, e};
    {req_addr, req_wdata, req_valid} = {a, d, 1'b1};
    while (req_ready !== 1'b1 || main_bus_busy !== 1'b0) @(posedge clock) #1;
    @(posedge clock) #1;
    req_valid = 1'b0;
    while (rsp_valid !== 1'b1 && n < 64) begin
      @(posedge clock) #1;
      n++;
    end
    chk(rsp_valid, 1'b1);
    chk({tgt_write, tgt_bus}, {w, b});
    chk(req_ready, 1'b1);
  endtask
  // Every bus code at equal clocks: no sync wait anywhere
  task automatic t_codes();
    req_periph_cycles = 4'h2;
    for (int b = 0; b < 8; b++) begin
      acc(3'(b), 1'b1, 1'b0, 1'b0, 32'h0, 32'h0);
      chk(rsp_cycles, 8'h03);
    end
  endtask
  // Slow target clocks, varied phase; last two never synchronise
  task automatic t_ratio();
    logic [2:0] bs[5] = '{3'h2, 3'h3, 3'h7, 3'h7, 3'h1};
    logic [7:0] hi[5] = '{8'h05, 8'h04, 8'h06, 8'h02, 8'h02};
    {pclk_div, flash_interface_clock_div, bclk_div, req_periph_cycles} = 16'h4351;
    for (int r = 0; r < 4; r++) begin
      for (int i = 0; i < 5; i++) begin
        repeat (r) @(posedge clock) #1;
        acc(bs[i], 1'b1, i == 1, i == 3, 32'h0, 32'h0);
        chk(rsp_cycles >= 8'h02 && rsp_cycles <= hi[i], 1'b1);
      end
    end
  endtask
  // Two writes, then read back only the last one
  task automatic t_rbw();
    acc(IORT_BUS_P2, 1'b1, 1'b0, 1'b0, 32'h0, 32'hA5A50001);
    acc(IORT_BUS_P6, 1'b1, 1'b0, 1'b0, 32'h4, 32'h5A5A0002);
    chk(rsp_rdata, 32'h0);
    acc(IORT_BUS_P6, 1'b0, 1'b0, 1'b0, 32'h4, 32'h0);
    chk(rsp_rdata, 32'h5A5A0002);
  endtask
  // Another master holds the main bus for five cycles
  task automatic t_busy();
    {pclk_div, req_periph_cycles, main_bus_busy, req_valid} = 10'h00F;
    repeat (5) @(posedge clock) #1;
    chk(req_ready, 1'b1);
    chk(tgt_strobe, 1'b0);
    main_bus_busy = 1'b0;
    acc(IORT_BUS_P2, 1'b1, 1'b0, 1'b0, 32'h8, 32'h0);
    chk(rsp_cycles, 8'h04);
  endtask
  // Reset in mid-access, then a read right after release
  task automatic t_reset();
    pclk_div = 4'h4;
    {req_bus, req_write, req_valid} = {IORT_BUS_P2, 1'b0, 1'b1};
    @(posedge clock) #1;
    {req_valid, srst} = 2'b01;
    repeat (2) @(posedge clock) #1;
    chk({req_ready, rsp_valid, tgt_strobe, tgt_bus}, 6'h20);
    chk(rsp_rdata, 32'h0);
    chk(rsp_cycles, 8'h00);
    srst = 1'b0;
    acc(IORT_BUS_P1, 1'b0, 1'b0, 1'b0, 32'h8, 32'h0);
    chk(rsp_cycles, 8'h04);
    chk(rsp_rdata, 32'h0);
  endtask
  task automatic tally_and_finish();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clock) #1;
    srst = 1'b0;
    t_codes();
    t_ratio();
    t_rbw();
    t_busy();
    t_reset();
    tally_and_finish();
  end
endmodule
`default_nettype wire
